// ---- rtl/touch_seq_pkg.sv ----
/*
 * Constants shared by the touch screen conversion sequencer: register offsets,
 * field positions, reset values, mode codes, channel numbers and timing counts.
 * Assumes a 100 MHz conversion clock, so one clock period is one conversion clock.
 */
package touch_seq_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets.
    localparam logic [3:0] OFS_CONVERSION_CONTROL = 4'h1;
    localparam logic [3:0] OFS_SEQUENCE_AND_ALERT_CONFIG = 4'h3;
    localparam logic [3:0] OFS_SPARE_BATTERY_UPPER_BOUND = 4'h4;
    localparam logic [3:0] OFS_SPARE_BATTERY_LOWER_BOUND = 4'h5;
    localparam logic [3:0] OFS_THERMAL_UPPER_BOUND = 4'h6;
    localparam logic [3:0] OFS_THERMAL_LOWER_BOUND = 4'h7;
    localparam logic [3:0] OFS_RESULT_FIRST = 4'h8;
    localparam logic [3:0] OFS_RESULT_LAST = 4'hd;
    localparam logic [3:0] OFS_PART_IDENTITY = 4'he;

    localparam logic [15:0] REG_RESET = 16'h0000;

    // Conversion control fields.
    localparam int TOUCH_DISABLE_BIT = 15;
    localparam int CHAN_HI = 14;
    localparam int CHAN_LO = 12;
    localparam int MODE_HI = 11;
    localparam int MODE_LO = 10;
    localparam int SAMPLE_WINDOW_HI = 9;
    localparam int SAMPLE_WINDOW_LO = 8;
    localparam int REPEAT_INTERVAL_HI = 7;
    localparam int REPEAT_INTERVAL_LO = 0;

    // Sequence and alert configuration fields.
    localparam int THERMAL_MASK_BIT = 15;
    localparam int SPARE_BATTERY_MASK_BIT = 14;
    localparam int LIMIT_ALERT_MODE_BIT = 13;
    localparam int GPIO_ALERT_MASK_BIT = 12;
    localparam int SPARE_BATTERY_LOW_BIT = 11;
    localparam int SPARE_BATTERY_HIGH_BIT = 10;
    localparam int THERMAL_LOW_BIT = 9;
    localparam int THERMAL_HIGH_BIT = 8;
    localparam int SELECT_HI = 7;
    localparam int SELECT_LO = 1;

    // Mode codes.
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_HOST_SEQUENCE = 2'h2;
    localparam logic [1:0] MODE_SELF_RUNNING = 2'h3;

    // Channels in sequence order; channel n is selected by configuration bit 7-n.
    localparam int NUM_CHANNELS = 7;
    localparam int NUM_RESULTS = 6;
    localparam logic [2:0] CH_SPARE = 3'h4;
    localparam logic [2:0] CH_BATTERY = 3'h5;
    localparam logic [2:0] CH_THERMAL = 3'h6;
    localparam logic [2:0] CHAN_ADDR_TOP = 3'h7;
    localparam logic [2:0] CHAN_ADDR_INVALID = 3'h0;

    // Timing.
    localparam int CLOCK_MHZ = 100;
    localparam int TIMER_BASE_US = 550;
    localparam int TIMER_STEP_US = 35;
    localparam int TIMER_BASE_CYCLES = TIMER_BASE_US * CLOCK_MHZ;
    localparam int TIMER_STEP_CYCLES = TIMER_STEP_US * CLOCK_MHZ;
    localparam int SAMPLE_BASE_PERIODS = 4;
    localparam int COUNT_W = 20;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WAIT_TOUCH = 6'b000010,
        ST_NEXT = 6'b000100,
        ST_SAMPLE = 6'b001000,
        ST_CONVERT = 6'b010000,
        ST_INTERVAL = 6'b100000
    } seq_state_type;

endpackage : touch_seq_pkg

// ---- rtl/touch_adc_sequence_control.sv ----
/*
 * Conversion sequencer and register file of a resistive touch screen ADC.
 * Assumes a synchronous parallel register port in front of it (the serial
 * interface lives elsewhere) and an analog front end that converts one channel
 * per start pulse and answers with a done pulse and the result word.
 */
`timescale 1ns/100ps

module touch_adc_sequence_control
    import touch_seq_pkg::*;
#(
    parameter int TIMER_BASE = TIMER_BASE_CYCLES,
    parameter int TIMER_STEP = TIMER_STEP_CYCLES,
    parameter logic [3:0] REVISION = 4'h1, // Arbitrary.
    parameter logic [7:0] DEVICE_CODE = 8'h5a // Arbitrary.
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    // Panel and pin status.
    input wire logic touch_i,
    input wire logic gpio_enable_i,
    input wire logic gpio_alert_i,
    // Analog front end.
    output logic sample_o,
    output logic conv_start_o,
    output logic [2:0] conv_channel_o,
    input wire logic conv_done_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    // Shared touch_detect_output / alert pin, active low.
    output logic alert_n_o
);

    // Channel number from the three-bit address: 111 is channel 0, 001 channel 6.
    function automatic logic [2:0] chan_from_addr(input logic [2:0] addr);
        chan_from_addr = CHAN_ADDR_TOP - addr;
    endfunction : chan_from_addr

    // Spare and battery share one result slot.
    function automatic logic [2:0] result_slot(input logic [2:0] ch);
        if (ch == CH_BATTERY || ch == CH_THERMAL) begin
            result_slot = ch - 3'h1;
        end else begin
            result_slot = ch;
        end
    endfunction : result_slot

    // Lowest pending channel number.
    function automatic logic [2:0] first_pending(input logic [NUM_CHANNELS-1:0] p);
        first_pending = 3'h0;
        for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
            if (p[i]) begin
                first_pending = i[2:0];
            end
        end
    endfunction : first_pending

    logic [15:0] conversion_control;
    logic [7:0] alert_config;
    logic [6:0] channel_select;
    logic [3:0] limit_flags;
    logic [15:0] spare_battery_upper_bound;
    logic [15:0] spare_battery_lower_bound;
    logic [15:0] thermal_upper_bound;
    logic [15:0] thermal_lower_bound;
    logic [15:0] result [NUM_RESULTS];
    logic new_result;
    logic mode_clear;
    logic need_release;
    seq_state_type state;
    logic [NUM_CHANNELS-1:0] pending;
    logic [COUNT_W-1:0] count;

    logic ctrl1_write;
    logic ctrl3_write;
    logic result_read;
    logic [1:0] mode;
    logic [7:0] interval_code;
    logic [NUM_CHANNELS-1:0] effective_select;
    logic [NUM_CHANNELS-1:0] launch_set;
    logic [COUNT_W-1:0] sample_load;
    logic [COUNT_W-1:0] interval_load;
    logic [31:0] interval_wide;
    logic store;
    logic [3:0] next_flags_set;
    logic limit_alert;

    assign ctrl1_write = reg_wr_i && reg_addr_i == OFS_CONVERSION_CONTROL;
    assign ctrl3_write = reg_wr_i && reg_addr_i == OFS_SEQUENCE_AND_ALERT_CONFIG;
    assign result_read = reg_rd_i && reg_addr_i >= OFS_RESULT_FIRST
        && reg_addr_i <= OFS_RESULT_LAST;
    assign mode = conversion_control[MODE_HI:MODE_LO];
    assign interval_code = conversion_control[REPEAT_INTERVAL_HI:REPEAT_INTERVAL_LO];
    assign store = state == ST_CONVERT && conv_done_i;

    // Configuration bit 7-n selects channel n; the pin function hides the spare
    // and battery inputs, and battery wins when both are asked for.
    always_comb begin
        for (int n = 0; n < NUM_CHANNELS; n++) begin
            effective_select[n] = channel_select[NUM_CHANNELS - 1 - n];
        end
        if (gpio_enable_i) begin
            effective_select[CH_SPARE] = 1'b0;
            effective_select[CH_BATTERY] = 1'b0;
        end else if (effective_select[CH_BATTERY]) begin
            effective_select[CH_SPARE] = 1'b0;
        end
    end

    // Single mode converts the addressed channel; the invalid address gives none.
    always_comb begin
        launch_set = effective_select;
        if (mode == MODE_SINGLE) begin
            launch_set = '0;
            if (conversion_control[CHAN_HI:CHAN_LO] != CHAN_ADDR_INVALID) begin
                launch_set[chan_from_addr(conversion_control[CHAN_HI:CHAN_LO])] = 1'b1;
            end
        end
    end

    assign sample_load = COUNT_W'((SAMPLE_BASE_PERIODS
        << conversion_control[SAMPLE_WINDOW_HI:SAMPLE_WINDOW_LO]) - 1);
    assign interval_wide = 32'(TIMER_BASE) + 32'(TIMER_STEP) * (32'(interval_code) - 32'h1);
    assign interval_load = COUNT_W'(interval_wide - 32'h1);

    // Conversion control: host writes win over the hardware return to idle.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            conversion_control <= REG_RESET;
        end else if (ctrl1_write) begin
            conversion_control <= reg_wdata_i;
        end else if (mode_clear) begin
            conversion_control[MODE_HI:MODE_LO] <= MODE_IDLE;
        end
    end

    // Writable configuration and limit registers.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            alert_config <= 8'h00;
            channel_select <= 7'h00;
            spare_battery_upper_bound <= REG_RESET;
            spare_battery_lower_bound <= REG_RESET;
            thermal_upper_bound <= REG_RESET;
            thermal_lower_bound <= REG_RESET;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_SEQUENCE_AND_ALERT_CONFIG: begin
                    alert_config <= reg_wdata_i[15:8];
                    channel_select <= reg_wdata_i[SELECT_HI:SELECT_LO];
                end
                OFS_SPARE_BATTERY_UPPER_BOUND: spare_battery_upper_bound <= reg_wdata_i;
                OFS_SPARE_BATTERY_LOWER_BOUND: spare_battery_lower_bound <= reg_wdata_i;
                OFS_THERMAL_UPPER_BOUND: thermal_upper_bound <= reg_wdata_i;
                OFS_THERMAL_LOWER_BOUND: thermal_lower_bound <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Limit comparison of each finished spare, battery or thermal conversion.
    always_comb begin
        next_flags_set = 4'h0;
        if (store && (conv_channel_o == CH_SPARE || conv_channel_o == CH_BATTERY)) begin
            next_flags_set[3] = conv_data_i < spare_battery_lower_bound;
            next_flags_set[2] = conv_data_i > spare_battery_upper_bound;
        end
        if (store && conv_channel_o == CH_THERMAL) begin
            next_flags_set[1] = conv_data_i < thermal_lower_bound;
            next_flags_set[0] = conv_data_i > thermal_upper_bound;
        end
    end

    // The flags stay set until software writes a one to them; a new hit in the
    // same cycle survives the clear so no out-of-limit event is lost.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            limit_flags <= 4'h0;
        end else begin
            limit_flags <= (limit_flags & ~(ctrl3_write
                ? reg_wdata_i[SPARE_BATTERY_LOW_BIT:THERMAL_HIGH_BIT] : 4'h0))
                | next_flags_set;
        end
    end

    // Result registers, read-only to the host.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_RESULTS; i++) begin
                result[i] <= REG_RESET;
            end
        end else if (store) begin
            result[result_slot(conv_channel_o)] <= conv_data_i;
        end
    end

    // Sequencer. Any write of the conversion control register restarts it, which
    // is why the host must program everything else first.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            pending <= '0;
            count <= '0;
            need_release <= 1'b0;
            mode_clear <= 1'b0;
            sample_o <= 1'b0;
            conv_start_o <= 1'b0;
            conv_channel_o <= 3'h0;
        end else begin
            mode_clear <= 1'b0;
            conv_start_o <= 1'b0;
            if (ctrl1_write) begin
                sample_o <= 1'b0;
                need_release <= 1'b0;
                pending <= '0;
                unique case (reg_wdata_i[MODE_HI:MODE_LO])
                    MODE_SINGLE, MODE_HOST_SEQUENCE: state <= ST_NEXT;
                    MODE_SELF_RUNNING: state <= ST_WAIT_TOUCH;
                    default: state <= ST_IDLE;
                endcase
                if (reg_wdata_i[MODE_HI:MODE_LO] != MODE_SELF_RUNNING) begin
                    pending <= '1;
                end
            end else begin
                unique case (state)
                    ST_IDLE: begin
                    end
                    ST_WAIT_TOUCH: begin
                        if (!touch_i) begin
                            need_release <= 1'b0;
                        end else if (!need_release) begin
                            pending <= '1;
                            state <= ST_NEXT;
                        end
                    end
                    ST_NEXT: begin
                        if ((pending & launch_set) != '0) begin
                            conv_channel_o <= first_pending(pending & launch_set);
                            pending <= pending & launch_set
                                & ~(7'h01 << first_pending(pending & launch_set));
                            count <= sample_load;
                            sample_o <= 1'b1;
                            state <= ST_SAMPLE;
                        end else if (interval_code == 8'h00) begin
                            if (mode == MODE_SELF_RUNNING) begin
                                need_release <= 1'b1;
                                state <= ST_WAIT_TOUCH;
                            end else begin
                                mode_clear <= 1'b1;
                                state <= ST_IDLE;
                            end
                        end else if (mode == MODE_SELF_RUNNING && !touch_i) begin
                            state <= ST_WAIT_TOUCH;
                        end else begin
                            count <= interval_load;
                            state <= ST_INTERVAL;
                        end
                    end
                    ST_SAMPLE: begin
                        if (count == '0) begin
                            sample_o <= 1'b0;
                            conv_start_o <= 1'b1;
                            state <= ST_CONVERT;
                        end else begin
                            count <= count - COUNT_W'(1);
                        end
                    end
                    ST_CONVERT: begin
                        if (conv_done_i) begin
                            state <= ST_NEXT;
                        end
                    end
                    ST_INTERVAL: begin
                        if (mode == MODE_SELF_RUNNING && !touch_i) begin
                            state <= ST_WAIT_TOUCH;
                        end else if (count == '0) begin
                            pending <= '1;
                            state <= ST_NEXT;
                        end else begin
                            count <= count - COUNT_W'(1);
                        end
                    end
                endcase
            end
        end
    end

    // New data is flagged at the end of each pass and cleared by reading any
    // result register; a pass ending on that very cycle keeps the flag set.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            new_result <= 1'b0;
        end else if (state == ST_NEXT && (pending & launch_set) == '0 && !ctrl1_write) begin
            new_result <= 1'b1;
        end else if (result_read) begin
            new_result <= 1'b0;
        end
    end

    // The alert mode bit overrides the masks: in new-result mode they are ignored.
    assign limit_alert =
        (|limit_flags[1:0] && !alert_config[THERMAL_MASK_BIT - 8])
        || (|limit_flags[3:2] && !alert_config[SPARE_BATTERY_MASK_BIT - 8])
        || (gpio_alert_i && !alert_config[GPIO_ALERT_MASK_BIT - 8]);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            alert_n_o <= 1'b1;
        end else if (!conversion_control[TOUCH_DISABLE_BIT]) begin
            alert_n_o <= !touch_i;
        end else if (alert_config[LIMIT_ALERT_MODE_BIT - 8]) begin
            alert_n_o <= !limit_alert;
        end else begin
            alert_n_o <= !new_result;
        end
    end

    // Read data is registered one cycle after the read strobe.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= REG_RESET;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_CONVERSION_CONTROL: reg_rdata_o <= conversion_control;
                OFS_SEQUENCE_AND_ALERT_CONFIG: begin
                    reg_rdata_o <= {alert_config[7:4], limit_flags, channel_select, 1'b0};
                end
                OFS_SPARE_BATTERY_UPPER_BOUND: reg_rdata_o <= spare_battery_upper_bound;
                OFS_SPARE_BATTERY_LOWER_BOUND: reg_rdata_o <= spare_battery_lower_bound;
                OFS_THERMAL_UPPER_BOUND: reg_rdata_o <= thermal_upper_bound;
                OFS_THERMAL_LOWER_BOUND: reg_rdata_o <= thermal_lower_bound;
                OFS_PART_IDENTITY: reg_rdata_o <= {4'h0, REVISION, DEVICE_CODE};
                default: begin
                    if (result_read) begin
                        reg_rdata_o <= result[3'(reg_addr_i - OFS_RESULT_FIRST)];
                    end else begin
                        reg_rdata_o <= REG_RESET;
                    end
                end
            endcase
        end
    end

endmodule : touch_adc_sequence_control

// ---- tb/touch_seq_checker_asserts.sv ----
/* Port-level properties of the touch sequencer.
   Assumes the hand-over timing of the register port and the front end. */
`timescale 1ns/100ps
module touch_seq_checker
    import touch_seq_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h1, // Arbitrary.
    parameter logic [7:0] DEVICE_CODE = 8'h5a // Arbitrary.
) (
    // Clock, reset and register port.
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    // Panel and front end.
    input wire logic touch_i,
    input wire logic gpio_enable_i,
    input wire logic sample_o,
    input wire logic conv_start_o,
    input wire logic [2:0] conv_channel_o,
    input wire logic alert_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic armed, touch_off;
    logic [1:0] mode_w;
    logic [7:1] sel_w;
    // Shadows follow host writes only; hardware return-to-idle never yields single mode.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            armed <= 1'b0;
            touch_off <= 1'b0;
            mode_w <= MODE_IDLE;
            sel_w <= 7'h00;
        end else begin
            armed <= 1'b1;
            if (reg_wr_i && reg_addr_i == OFS_CONVERSION_CONTROL) begin
                touch_off <= reg_wdata_i[TOUCH_DISABLE_BIT];
                mode_w <= reg_wdata_i[MODE_HI:MODE_LO];
            end
            if (reg_wr_i && reg_addr_i == OFS_SEQUENCE_AND_ALERT_CONFIG) begin
                sel_w <= reg_wdata_i[7:1];
            end
        end
    end
    AST_ID_READ: assert property (reg_rd_i && reg_addr_i == OFS_PART_IDENTITY |=>
        reg_rdata_o == {4'h0, REVISION, DEVICE_CODE}) else $error("identity read wrong");
    AST_UNMAPPED_READ: assert property (reg_rd_i && reg_addr_i == 4'h2 |=>
        reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    AST_START_ENDS_SAMPLE: assert property (conv_start_o |-> !sample_o && $past(sample_o))
        else $error("start not at end of sampling");
    AST_MIN_WINDOW: assert property ($rose(sample_o) |-> sample_o[*4])
        else $error("sampling window too short");
    AST_CHANNEL_STEADY: assert property (sample_o && $past(sample_o) |->
        $stable(conv_channel_o)) else $error("channel moved while sampling");
    AST_PIN_SKIPS: assert property (sample_o && gpio_enable_i && mode_w != MODE_SINGLE |->
        conv_channel_o != CH_SPARE && conv_channel_o != CH_BATTERY) else $error("pin skip");
    AST_BATTERY_WINS: assert property (sample_o && sel_w[2] && mode_w != MODE_SINGLE |->
        conv_channel_o != CH_SPARE) else $error("spare converted beside battery");
    AST_TOUCH_PIN: assert property (armed && !$past(touch_off) |->
        alert_n_o == !$past(touch_i)) else $error("touch output wrong");
    COV_START: cover property (conv_start_o);
    COV_ID: cover property (reg_rd_i && reg_addr_i == OFS_PART_IDENTITY);
    COV_ALERT: cover property (touch_off && !alert_n_o);
endmodule : touch_seq_checker

bind touch_adc_sequence_control touch_seq_checker #(.REVISION(REVISION),
    .DEVICE_CODE(DEVICE_CODE)) u_touch_seq_checker (.clock_i(clock_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .touch_i(touch_i),
    .gpio_enable_i(gpio_enable_i), .sample_o(sample_o), .conv_start_o(conv_start_o),
    .conv_channel_o(conv_channel_o), .alert_n_o(alert_n_o));

// ---- tb/touch_front_end_model.sv ----
/* Behavioural analog front end: one conversion per start, random result.
   Assumes the sequencer starts one conversion at a time. */
`timescale 1ns/100ps
module touch_front_end_model (
    // Clock and converter side.
    input wire logic clock_i,
    input wire logic sample_i,
    input wire logic conv_start_i,
    input wire logic [2:0] conv_channel_i,
    output logic conv_done_o,
    output logic [15:0] conv_data_o
);
    logic [15:0] last [0:6];
    logic [2:0] ch;
    int sample_len = 0, convs = 0, n = 0;
    initial begin
        conv_done_o = 1'b0;
        conv_data_o = 16'h0000;
        forever begin
            @(posedge clock_i);
            if (sample_i) n++;
            if (conv_start_i) begin
                sample_len = n;
                n = 0;
                ch = conv_channel_i;
                repeat ($urandom_range(1, 6)) @(negedge clock_i);
                conv_data_o = 16'($urandom);
                last[ch] = conv_data_o;
                conv_done_o = 1'b1;
                @(negedge clock_i);
                conv_done_o = 1'b0;
                // Data is stale after the pulse, so show something else.
                conv_data_o = ~conv_data_o;
                convs++;
            end
        end
    end
endmodule : touch_front_end_model

// ---- tb/tb_touch_adc_sequence_control.sv ----
/* Self-checking bench for the touch sequencer with a front end model.
   Assumes shortened interval counts so repeated passes fit a short run. */
`timescale 1ns/100ps
module tb_touch_adc_sequence_control;
    import touch_seq_pkg::*;
    localparam logic [3:0] REV = 4'h3; // Arbitrary.
    localparam logic [7:0] DEV = 8'hc6; // Arbitrary.
    logic clock_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, touch_i = 1'b0;
    logic gpio_enable_i = 1'b0, gpio_alert_i = 1'b0, sample_o, conv_start_o, conv_done_i, alert_n_o;
    logic [3:0] reg_addr_i = 4'h0, flags;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, conv_data_i, rv;
    logic [15:0] lim [4:7];
    logic [15:0] res [8:13] = '{default: 16'h0000};
    logic [2:0] conv_channel_o;
    int error_cnt = 0, comparisons = 0, n, m;
    always #5 clock_i = ~clock_i;
    touch_adc_sequence_control #(.TIMER_BASE(20), .TIMER_STEP(5), .REVISION(REV),
        .DEVICE_CODE(DEV)) u_touch_adc_sequence_control (.clock_i(clock_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .touch_i(touch_i),
        .gpio_enable_i(gpio_enable_i), .gpio_alert_i(gpio_alert_i), .sample_o(sample_o),
        .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .alert_n_o(alert_n_o));
    touch_front_end_model u_touch_front_end_model (.clock_i(clock_i), .sample_i(sample_o),
        .conv_start_i(conv_start_o), .conv_channel_i(conv_channel_o),
        .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results;
        if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge clock_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(negedge clock_i);
        {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        rv = reg_rdata_o;
    endtask : rd
    task automatic wait_cycles(input int c);
        repeat (c) @(negedge clock_i);
    endtask : wait_cycles
    function automatic logic alert_exp(input logic t, input logic [3:0] h, f, input logic g);
        if (!t) return 1'b1;
        if (!h[1]) return 1'b0;
        return !((|f[1:0] && !h[3]) || (|f[3:2] && !h[2]) || (g && !h[0]));
    endfunction : alert_exp
    // One host-triggered pass with random channels, masks and limits, and window k[1:0].
    task automatic pass(input logic [2:0] k);
        logic [7:0] sel, eff;
        logic [3:0] hi;
        logic t, g;
        logic [2:0] ca;
        logic [15:0] d;
        {sel, hi, t, g} = 14'($urandom);
        sel = sel & 8'hfe | 8'h80 | {4'h0, k[2], k[2], 2'b00};
        for (int i = 4; i < 8; i++) begin
            lim[i] = 16'($urandom);
            wr(4'(i), lim[i]);
            rd(4'(i));
            check("limit", rv, lim[i]);
        end
        {gpio_enable_i, gpio_alert_i} = {g, 1'($urandom)};
        eff = sel;
        if (g) eff[3:2] = 2'b00;
        else if (sel[2]) eff[3] = 1'b0;
        ca = (k[2] && k[0]) ? (sel[6:4] | 3'h1) : 3'h0;
        if (ca != 3'h0) eff = 8'h01 << ca;
        wr(OFS_SEQUENCE_AND_ALERT_CONFIG, {hi, 4'hf, sel});
        wr(OFS_CONVERSION_CONTROL, {t, ca, ((ca != 3'h0) ? MODE_SINGLE : MODE_HOST_SEQUENCE),
            k[1:0], 8'h00});
        n = 0;
        do begin
            rd(OFS_CONVERSION_CONTROL);
            n++;
        end while (rv[11:10] !== MODE_IDLE && n < 500);
        check("control", rv, {t, ca, MODE_IDLE, k[1:0], 8'h00});
        check("window", 16'(u_touch_front_end_model.sample_len), 16'(4 << k[1:0]));
        flags = 4'h0;
        for (int c = 0; c < 7; c++) begin
            if (eff[7 - c]) begin
                d = u_touch_front_end_model.last[c];
                res[c < 4 ? 8 + c : (c == 6 ? 13 : 12)] = d;
                if (c == 6) flags[1:0] = flags[1:0] | {d < lim[7], d > lim[6]};
                else if (c > 3) flags[3:2] = flags[3:2] | {d < lim[5], d > lim[4]};
            end
        end
        wait_cycles(2);
        check("alert", 16'(alert_n_o), 16'(alert_exp(t, hi, flags, gpio_alert_i)));
        for (int a = 8; a < 14; a++) begin
            rd(4'(a));
            check("result", rv, res[a]);
        end
        rd(OFS_SEQUENCE_AND_ALERT_CONFIG);
        check("config", rv, {hi, flags, sel});
    endtask : pass
    initial begin
        void'($urandom(99));
        wait_cycles(8);
        rst_i = 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a));
            check("reset", rv, a == 14 ? {4'h0, REV, DEV} : 16'h0000);
        end
        wr(4'h8, 16'hffff);
        rd(4'h8);
        check("readonly", rv, 16'h0000);
        for (int k = 0; k < 8; k++) pass(3'(k));
        wr(OFS_SEQUENCE_AND_ALERT_CONFIG, 16'h0f80);
        n = u_touch_front_end_model.convs;
        wr(OFS_CONVERSION_CONTROL, {4'h0, MODE_HOST_SEQUENCE, 2'b00, 8'h02});
        wait_cycles(300);
        check("repeats", 16'((u_touch_front_end_model.convs - n) inside {[7:10]}),
            16'h0001);
        m = 0;
        while (!conv_start_o && m < 100) begin
            wait_cycles(1);
            m++;
        end
        wr(OFS_CONVERSION_CONTROL, {4'h0, MODE_SELF_RUNNING, 2'b00, 8'h01});
        wait_cycles(60);
        n = u_touch_front_end_model.convs;
        wait_cycles(60);
        check("untouched", 16'(u_touch_front_end_model.convs - n), 16'h0000);
        touch_i = 1'b1;
        m = 0;
        while (!sample_o && m < 20) begin
            wait_cycles(1);
            m++;
        end
        check("launch", 16'(m < 6), 16'h0001);
        wait_cycles(200);
        check("touched", 16'(u_touch_front_end_model.convs - n > 3), 16'h0001);
        touch_i = 1'b0;
        wait_cycles(40);
        n = u_touch_front_end_model.convs;
        wait_cycles(100);
        check("released", 16'(u_touch_front_end_model.convs - n), 16'h0000);
        results();
    end
    initial begin
        #400000;
        error_cnt++;
        results();
    end
endmodule : tb_touch_adc_sequence_control
